// File: design/serial_eeprom_command_engine.sv
// Command engine of a two-wire serial memory slave with 128 KiB array
// and a lockable identification page. Assumes bus pins asynchronous to
// ref_clk; the bench resolves the open-drain data wire from sda_oe.
// Behaviour
// - Acknowledge both write address bytes low
// - Stop ends write, starts timed cycle
// - Page write stores up to 256 bytes
// - Acknowledge every data byte except locked id page data
// - Write increments only low eight bits
// - In-page address wraps to page start
// - Id page write uses type 1011b
// - Locked id page data not acknowledged
// - Polling acknowledged only after cycle ends
// - Read forms set direction bit one
// - Counter holds last address plus one
// - Read counter wraps end to start
// - Current read shifts byte at counter
// - Sequential read continues while acknowledged
// - Id page read uses type 1011b
// - Lock command freezes id page until reset
// - Cycle time counted from valid stop
// - Device byte checks type and selects
// - Write protect blocks array programming
// - Acknowledge driven during ninth clock
// - Start and stop detected while clock high
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_engine #(
   parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic chip_select_high_pin,
   input wire logic chip_select_low_pin,
   input wire logic write_protect,
   output logic busy,
   output logic id_locked
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   logic [1:0] scl_s_q, sda_s_q, wp_s_q, csh_s_q, csl_s_q;
   logic scl_q, sda_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         wp_s_q <= 2'h0;
         csh_s_q <= 2'h0;
         csl_s_q <= 2'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         wp_s_q <= {wp_s_q[0], write_protect};
         csh_s_q <= {csh_s_q[0], chip_select_high_pin};
         csl_s_q <= {csl_s_q[0], chip_select_low_pin};
         scl_q <= scl_s_q[1];
         sda_q <= sda_s_q[1];
      end
   end
   logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
   assign scl = scl_s_q[1];
   assign sda = sda_s_q[1];
   assign scl_rise = scl && !scl_q;
   assign scl_fall = !scl && scl_q;
   assign start_ev = scl && scl_q && sda_q && !sda;
   assign stop_ev = scl && scl_q && !sda_q && sda;

   ////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0] mem [0:eeprom_pkg::ARRAY_BYTES-1];
   logic [7:0] idmem [0:eeprom_pkg::PAGE_BYTES-1];
   logic [7:0] pbuf [0:eeprom_pkg::PAGE_BYTES-1];
   logic [255:0] pvalid_q;

   ////////////////////////////////////////////////////////////////////
   // Byte framing
   eeprom_pkg::state_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic ninth;
   assign ninth = (bit_q == 4'h8);
   logic [16:0] addr_q;
   logic [16:0] waddr_q;
   logic idsel_q, wr_pend_q, lock_pend_q, nack_q, ack_q;
   logic [7:0] rbyte_q;
   logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_q;
   eeprom_pkg::dev_addr_t dev;
   assign dev = eeprom_pkg::dev_addr_t'({sh_q[6:0], sda});

   function automatic logic dev_match(input eeprom_pkg::dev_addr_t d,
         input logic hi, input logic lo);
      dev_match = (d.dev_type == eeprom_pkg::TYPE_ARRAY ||
         d.dev_type == eeprom_pkg::TYPE_IDPAGE) &&
         d.chip_sel == {hi, lo};
   endfunction

   logic byte_done;
   assign byte_done = scl_rise && (bit_q == 4'h7);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bit_q <= 4'h0;
         sh_q <= 8'h00;
      end else if (start_ev || stop_ev) begin
         bit_q <= 4'h0;
      end else if (scl_rise && bit_q < 4'h8) begin
         sh_q <= {sh_q[6:0], sda};
         bit_q <= bit_q + 4'h1;
      end else if (scl_rise && ninth) begin
         bit_q <= 4'h9;
      end else if (scl_fall && bit_q == 4'h9) begin
         bit_q <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= eeprom_pkg::ST_IDLE;
         addr_q <= eeprom_pkg::ADDR_RESET;
         waddr_q <= eeprom_pkg::ADDR_RESET;
         idsel_q <= 1'b0;
         ack_q <= 1'b0;
         wr_pend_q <= 1'b0;
         lock_pend_q <= 1'b0;
         nack_q <= 1'b0;
         pvalid_q <= '0;
      end else if (busy) begin
         st_q <= eeprom_pkg::ST_IDLE;
         ack_q <= 1'b0;
      end else if (start_ev) begin
         st_q <= eeprom_pkg::ST_DEV;
         ack_q <= 1'b0;
         wr_pend_q <= 1'b0;
         lock_pend_q <= 1'b0;
         pvalid_q <= '0;
      end else if (stop_ev) begin
         st_q <= eeprom_pkg::ST_IDLE;
         ack_q <= 1'b0;
      end else begin
         if (byte_done) begin
            ack_q <= 1'b0;
         end
         case (st_q)
            eeprom_pkg::ST_DEV: begin
               if (byte_done) begin
                  if (!dev_match(dev, csh_s_q[1], csl_s_q[1])) begin
                     st_q <= eeprom_pkg::ST_IGNORE;
                  end else begin
                     ack_q <= 1'b1;
                     idsel_q <= dev.dev_type == eeprom_pkg::TYPE_IDPAGE;
                     if (dev.read) begin
                        st_q <= eeprom_pkg::ST_RDATA;
                     end else begin
                        addr_q[16] <= dev.top_address_bit;
                        st_q <= eeprom_pkg::ST_ADDR_HI;
                     end
                  end
               end
            end
            eeprom_pkg::ST_ADDR_HI: begin
               if (byte_done) begin
                  addr_q[15:8] <= {sh_q[6:0], sda};
                  ack_q <= 1'b1;
                  st_q <= eeprom_pkg::ST_ADDR_LO;
               end
            end
            eeprom_pkg::ST_ADDR_LO: begin
               if (byte_done) begin
                  addr_q[7:0] <= {sh_q[6:0], sda};
                  ack_q <= 1'b1;
                  waddr_q <= {addr_q[16:8], sh_q[6:0], sda};
                  nack_q <= idsel_q && id_locked &&
                     !addr_q[8 + eeprom_pkg::LOCK_SEL_POS];
                  st_q <= eeprom_pkg::ST_WDATA;
               end
            end
            eeprom_pkg::ST_WDATA: begin
               if (byte_done) begin
                  pbuf[waddr_q[7:0]] <= {sh_q[6:0], sda};
                  pvalid_q[waddr_q[7:0]] <= 1'b1;
                  ack_q <= !nack_q;
                  waddr_q[7:0] <= waddr_q[7:0] + 8'h01;
                  addr_q <= {waddr_q[16:8], waddr_q[7:0] + 8'h01};
                  if (idsel_q && waddr_q[8 + eeprom_pkg::LOCK_SEL_POS]) begin
                     lock_pend_q <= sh_q[eeprom_pkg::LOCK_DATA_POS - 1];
                  end else if (!nack_q) begin
                     wr_pend_q <= 1'b1;
                  end
               end
            end
            eeprom_pkg::ST_RDATA: begin
               if (byte_done) begin
                  addr_q <= addr_q + 17'h00001;
                  st_q <= eeprom_pkg::ST_RACK;
               end
            end
            eeprom_pkg::ST_RACK: begin
               if (scl_rise) begin
                  st_q <= sda ? eeprom_pkg::ST_IGNORE :
                     eeprom_pkg::ST_RDATA;
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data shift and acknowledge drive
   logic [7:0] rd_src;
   assign rd_src = idsel_q ? idmem[addr_q[7:0]] : mem[addr_q];
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rbyte_q <= 8'h00;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         if (busy || start_ev || stop_ev) begin
            sda_oe <= 1'b0;
         end else if (scl_fall && ninth) begin
            sda_oe <= ack_q;
         end else if (scl_fall && bit_q == 4'h9) begin
            sda_oe <= 1'b0;
            if (st_q == eeprom_pkg::ST_RDATA) begin
               sda_oe <= !rd_src[7];
               rbyte_q <= {rd_src[6:0], 1'b1};
            end
         end else if (scl_fall && st_q == eeprom_pkg::ST_RDATA) begin
            sda_oe <= !rbyte_q[7];
            rbyte_q <= {rbyte_q[6:0], 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Programming cycle and nonvolatile commit
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prog_cnt_q <= '0;
         id_locked <= eeprom_pkg::LOCK_RESET;
      end else if (prog_cnt_q != '0) begin
         prog_cnt_q <= prog_cnt_q - 1'b1;
      end else if (stop_ev && (wr_pend_q || lock_pend_q) &&
            st_q == eeprom_pkg::ST_WDATA) begin
         prog_cnt_q <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES);
         if (lock_pend_q) begin
            id_locked <= 1'b1;
         end
      end
   end
   assign busy = prog_cnt_q != '0;

   always_ff @(posedge ref_clk) begin
      if (stop_ev && wr_pend_q && !busy && st_q == eeprom_pkg::ST_WDATA) begin
         for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
            if (pvalid_q[i]) begin
               if (idsel_q && !id_locked) begin
                  idmem[i] <= pbuf[i];
               end else if (!idsel_q && !wp_s_q[1]) begin
                  mem[{waddr_q[16:8], 8'(i)}] <= pbuf[i];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_busy_quiet;
      @(posedge ref_clk) disable iff (!rstn)
         busy |=> !sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("data driven during programming");
   property p_lock_sticky;
      @(posedge ref_clk) disable iff (!rstn)
         id_locked |=> id_locked;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock cleared");
   property p_stop_release;
      @(posedge ref_clk) disable iff (!rstn)
         stop_ev |=> !sda_oe;
   endproperty
   a_stop_release: assert property (p_stop_release)
      else $error("data driven after stop");
   property p_ignore_quiet;
      @(posedge ref_clk) disable iff (!rstn)
         st_q == eeprom_pkg::ST_IGNORE |=> !sda_oe;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet)
      else $error("unselected device drives");
   property p_wrap;
      @(posedge ref_clk) disable iff (!rstn)
         byte_done && st_q == eeprom_pkg::ST_WDATA && !busy &&
         !start_ev && !stop_ev
         |=> waddr_q[16:8] == $past(waddr_q[16:8]);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("page row changed");
   property p_prog_len;
      @(posedge ref_clk) disable iff (!rstn)
         $rose(busy) |-> busy [*8];
   endproperty
   a_prog_len: assert property (p_prog_len)
      else $error("programming cycle too short");
   property p_oe_low;
      @(posedge ref_clk) disable iff (!rstn)
         sda_oe && st_q != eeprom_pkg::ST_RDATA |->
         bit_q == 4'h8 || bit_q == 4'h9;
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("acknowledge outside ninth clock");
   property p_rd_inc;
      @(posedge ref_clk) disable iff (!rstn)
         st_q == eeprom_pkg::ST_RDATA && byte_done && !busy &&
         !start_ev && !stop_ev |=> addr_q == $past(addr_q) + 17'h00001;
   endproperty
   a_rd_inc: assert property (p_rd_inc)
      else $error("read counter not incremented");
endmodule
`default_nettype wire

// File: design/eeprom_pkg.sv
// Package for the two-wire serial memory command engine.
// Assumes a 125 MHz core clock sampling the bus pins.
package eeprom_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned PROG_TIME_US = 5000;
   localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam logic [3:0] TYPE_ARRAY = 4'ha;
   localparam logic [3:0] TYPE_IDPAGE = 4'hb;
   localparam int unsigned LOCK_SEL_POS = 2;
   localparam int unsigned LOCK_DATA_POS = 1;
   localparam logic [16:0] ADDR_RESET = 17'h00000;
   localparam logic LOCK_RESET = 1'b0;
   localparam int unsigned ARRAY_BYTES = 131072;
   localparam int unsigned PAGE_BYTES = 256;

   typedef struct packed {
      logic [3:0] dev_type;
      logic [1:0] chip_sel;
      logic top_address_bit;
      logic read;
   } dev_addr_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_DEV = 4'h1,
      ST_ADDR_HI = 4'h2,
      ST_ADDR_LO = 4'h3,
      ST_WDATA = 4'h4,
      ST_RDATA = 4'h5,
      ST_RACK = 4'h6,
      ST_IGNORE = 4'h7
   } state_t;
endpackage

// File: tb/i2c_ctrl_model.sv
// Bus controller model that drives the clock and open-drain data line.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   input wire logic ref_clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Start, also used as repeated start
   task automatic start();
      sda_low <= 1'b0;
      wt(5);
      scl <= 1'b1;
      wt(5);
      sda_low <= 1'b1;
      wt(5);
      scl <= 1'b0;
      wt(1);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      wt(4);
      scl <= 1'b1;
      wt(5);
      sda_low <= 1'b0;
      wt(10);
   endtask
   // One bit per 80 ns clock period
   task automatic clk_bit(input logic b, output logic r);
      sda_low <= ~b;
      wt(4);
      scl <= 1'b1;
      wt(4);
      r = sda_in;
      wt(1);
      scl <= 1'b0;
      wt(1);
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], r);
      end
      clk_bit(1'b1, r);
      ack = ~r;
   endtask
   // Last byte of a read is left unacknowledged
   task automatic rd(input logic ack_it, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(~ack_it, r);
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench with a byte-level memory model.
// Assumes the controller model and a shortened programming cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, rstn, scl, sda_low, sda_o, sda_oe, busy, id_locked;
   logic cs_hi, cs_lo, write_protect, locked;
   wire logic sda_line;
   int err_total, n_tests;
   logic [7:0] mem [int];
   logic [7:0] idmem [int];
   logic [16:0] ctr;
   assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
   serial_eeprom_command_engine #(.PROG_CYCLES(300)) uut (
      .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_high_pin(cs_hi),
      .chip_select_low_pin(cs_lo), .write_protect(write_protect),
      .busy(busy), .id_locked(id_locked));
   i2c_ctrl_model ctrl (.ref_clk(ref_clk), .sda_in(sda_line), .scl(scl),
      .sda_low(sda_low));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic hdr(input logic [3:0] ty, input logic [1:0] cs,
                      input logic a16, input logic r, output logic k);
      ctrl.start();
      ctrl.wr({ty, cs, a16, r}, k);
   endtask
   task automatic addr_ph(input logic [3:0] ty, input logic [16:0] a);
      logic k;
      hdr(ty, {cs_hi, cs_lo}, a[16], 1'b0, k);
      chk("dev ack", 8'h01, {7'h00, k});
      ctrl.wr(a[15:8], k);
      chk("addr hi ack", 8'h01, {7'h00, k});
      ctrl.wr(a[7:0], k);
      chk("addr lo ack", 8'h01, {7'h00, k});
   endtask
   task automatic wr_seq(input logic [3:0] ty, input logic [16:0] a,
                         input int n, input logic pchk);
      logic k, arr, nak;
      logic [7:0] d, lo;
      int tries;
      arr = (ty == eeprom_pkg::TYPE_ARRAY);
      nak = !arr && !a[10] && locked;
      lo = a[7:0];
      addr_ph(ty, a);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom) | {6'h00, !arr && a[10], 1'b0};
         ctrl.wr(d, k);
         if (!write_protect) chk("data ack", {7'h00, !nak}, {7'h00, k});
         if (arr && !write_protect) mem[{a[16:8], lo}] = d;
         if (!arr && !a[10] && !locked) idmem[lo] = d;
         lo++;
      end
      ctrl.stop();
      if (arr && !write_protect) chk("busy", 8'h01, {7'h00, busy});
      tries = 0;
      do begin
         hdr(eeprom_pkg::TYPE_ARRAY, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
         ctrl.stop();
         tries++;
      end while (!k && tries < 20);
      chk("poll ack", 8'h01, {7'h00, k});
      if (pchk) chk("poll nack first", 8'h01, {7'h00, tries > 1});
      if (!arr && a[10]) locked = 1'b1;
      chk("lock flag", {7'h00, locked}, {7'h00, id_locked});
   endtask
   task automatic rd_seq(input logic [3:0] ty, input logic [16:0] a,
                         input int n, input logic rnd);
      logic k, arr;
      logic [7:0] d, e;
      logic [16:0] p;
      arr = (ty == eeprom_pkg::TYPE_ARRAY);
      p = rnd ? a : ctr;
      if (rnd) addr_ph(ty, a);
      ctrl.start();
      ctrl.wr({ty, cs_hi, cs_lo, p[16], 1'b1}, k);
      chk("read dev ack", 8'h01, {7'h00, k});
      for (int i = 0; i < n; i++) begin
         ctrl.rd(i < n - 1, d);
         if (arr ? mem.exists(p) : idmem.exists(p[7:0])) begin
            e = arr ? mem[p] : idmem[p[7:0]];
            chk("rdata", e, d);
         end
         p = arr ? p + 17'h00001 : {p[16:8], p[7:0] + 8'h01};
      end
      ctrl.stop();
      if (arr) ctr = p;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic k;
      rstn = 1'b0;
      write_protect = 1'b0;
      cs_hi = 1'b0;
      cs_lo = 1'b0;
      locked = 1'b0;
      err_total = 0;
      n_tests = 0;
      void'($urandom(57848));
      repeat (4) @(posedge ref_clk);
      cs_hi <= 1'($urandom);
      cs_lo <= 1'($urandom);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("busy idle", 8'h00, {7'h00, busy});
      wr_seq(eeprom_pkg::TYPE_ARRAY, 17'h001fe, 4, 1'b1);
      rd_seq(eeprom_pkg::TYPE_ARRAY, 17'h001fe, 1, 1'b1);
      rd_seq(eeprom_pkg::TYPE_ARRAY, 17'h00000, 1, 1'b0);
      rd_seq(eeprom_pkg::TYPE_ARRAY, 17'h00100, 2, 1'b1);
      wr_seq(eeprom_pkg::TYPE_ARRAY, 17'h1ffff, 1, 1'b1);
      wr_seq(eeprom_pkg::TYPE_ARRAY, 17'h00000, 1, 1'b1);
      rd_seq(eeprom_pkg::TYPE_ARRAY, 17'h1ffff, 2, 1'b1);
      hdr(eeprom_pkg::TYPE_ARRAY, ~{cs_hi, cs_lo}, 1'b0, 1'b0, k);
      chk("cs mismatch", 8'h00, {7'h00, k});
      ctrl.stop();
      hdr(4'h5, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      chk("type mismatch", 8'h00, {7'h00, k});
      ctrl.stop();
      write_protect <= 1'b1;
      wr_seq(eeprom_pkg::TYPE_ARRAY, 17'h00100, 1, 1'b0);
      write_protect <= 1'b0;
      rd_seq(eeprom_pkg::TYPE_ARRAY, 17'h00100, 1, 1'b1);
      wr_seq(eeprom_pkg::TYPE_IDPAGE, 17'h1b0f0, 3, 1'b0);
      rd_seq(eeprom_pkg::TYPE_IDPAGE, 17'h0a0f0, 3, 1'b1);
      wr_seq(eeprom_pkg::TYPE_IDPAGE, 17'h00400, 1, 1'b0);
      wr_seq(eeprom_pkg::TYPE_IDPAGE, 17'h000f0, 2, 1'b0);
      rd_seq(eeprom_pkg::TYPE_IDPAGE, 17'h000f0, 3, 1'b1);
      end_sim();
   end
   initial begin
      #700000;
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire
